/* File: hw/spss_defs.svh */
/*
 Constants of the synchronous panel signal shaper: configuration bit positions,
 pixel formats, field widths and reset values.
 Assumes it is included by its bare name from the shaper's design files.
*/
// Summary of operation
// RULE1: Data mask bit forces all pixel lines zero.
// RULE2: Clock-idle bit stops pixel clock during vertical sync.
// RULE3: Clock-select bit stops pixel clock without data.
// RULE4: Bit 3 sets vertical sync active level.
// RULE5: Bit 4 sets data-valid active level.
// RULE6: Bit 5 inverts every pixel data bit.
// RULE7: Bit 6 inverts the pixel clock.
// RULE8: Bit 7 sets horizontal sync active level.
// RULE9: Eighteen-bit bus; drop colour low bits.
// RULE10: Panel pins driven only when interface enabled.
// RULE11: Frame pixels read as 565, 666 or 888.
// RULE12: Lines and frames: sync, back porch, active, front.
// RULE13: Configuration bits above seven are ignored.
`ifndef SPSS_DEFS_SVH
`define SPSS_DEFS_SVH

`define SPSS_CFG_W 32
`define SPSS_BIT_MASK 0
`define SPSS_BIT_CLKIDLE 1
`define SPSS_BIT_CLKSEL 2
`define SPSS_BIT_VPOL 3
`define SPSS_BIT_DEPOL 4
`define SPSS_BIT_DPOL 5
`define SPSS_BIT_CPOL 6
`define SPSS_BIT_HPOL 7
`define SPSS_CFG_USED 8
`define SPSS_PIX_IN_W 24
`define SPSS_PIX_OUT_W 18
`define SPSS_CNT_W 12
`define SPSS_DIV_W 8
`define SPSS_FMT_565 2'h0
`define SPSS_FMT_666 2'h1
`define SPSS_FMT_888 2'h2
`define SPSS_CFG_RST 8'h00

`endif

/* File: hw/spss_pkg.sv */
/*
 Types shared by the shaper's files: timing phases and the timing counter type.
 Assumes spss_defs.svh is on the include path.
*/
`include "spss_defs.svh"
package spss_pkg;
	typedef enum logic [1:0] {
		SPSS_PH_SYNC,
		SPSS_PH_BACK,
		SPSS_PH_ACTIVE,
		SPSS_PH_FRONT
	} spss_phase_e;
	typedef logic [`SPSS_CNT_W-1:0] spss_cnt_t;
endpackage

/* File: hw/spss_tick_if.sv */
/*
 Interface carrying the pixel-rate enable from the divider to the shaper top.
 Assumes one clock domain, sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
interface spss_tick_if;
	logic rise;
	logic fall;
	logic level;
	modport src (output rise, output fall, output level);
	modport dst (input rise, input fall, input level);
endinterface
`default_nettype wire

/* File: hw/spss_clk_div.sv */
/*
 Pixel clock divider: a square wave at sys_clk_i over twice the divide count,
 with one-cycle enables on each half.
 Assumes div_i is held steady while enabled; zero is treated as one.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spss_defs.svh"
module spss_clk_div (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic en_i,
	input wire logic [`SPSS_DIV_W-1:0] div_i,
	spss_tick_if.src tick
);
	logic [`SPSS_DIV_W-1:0] cnt_q;
	logic lvl_q;
	logic hit;
	logic [`SPSS_DIV_W-1:0] lim;

	assign lim = (div_i == '0) ? `SPSS_DIV_W'(1) : div_i;
	assign hit = en_i && (cnt_q >= lim - `SPSS_DIV_W'(1));

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
		end else if (!en_i || hit) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + `SPSS_DIV_W'(1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lvl_q <= 1'b0;
		end else if (!en_i) begin
			lvl_q <= 1'b0;
		end else if (hit) begin
			lvl_q <= ~lvl_q;
		end
	end

	assign tick.rise = hit && !lvl_q;
	assign tick.fall = hit && lvl_q;
	assign tick.level = lvl_q;
endmodule
`default_nettype wire

/* File: hw/spss_shaper.sv */
/*
 Synchronous RGB panel output stage: frame timing generator, pixel format
 reduction to eighteen lines, and per-signal polarity, masking and clock gating.
 Assumes pixel_i is supplied by a source that presents the next pixel whenever
 pixel_req_o pulses, and that timing counts are stable while enable_i is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spss_defs.svh"
module spss_shaper (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic enable_i,
	input wire logic [`SPSS_CFG_W-1:0] config_i,
	input wire logic [1:0] pixel_format_i,
	input wire logic [`SPSS_DIV_W-1:0] clk_div_i,
	input wire spss_pkg::spss_cnt_t h_sync_i,
	input wire spss_pkg::spss_cnt_t h_back_i,
	input wire spss_pkg::spss_cnt_t h_active_i,
	input wire spss_pkg::spss_cnt_t h_front_i,
	input wire spss_pkg::spss_cnt_t v_sync_i,
	input wire spss_pkg::spss_cnt_t v_back_i,
	input wire spss_pkg::spss_cnt_t v_active_i,
	input wire spss_pkg::spss_cnt_t v_front_i,
	input wire logic out_a_i,
	input wire logic [`SPSS_PIX_IN_W-1:0] pixel_i,
	output logic pixel_req_o,
	output logic frame_start_o,
	output logic [`SPSS_PIX_OUT_W-1:0] pixel_bus_out_o,
	output logic vsync_o,
	output logic hsync_o,
	output logic data_valid_out_o,
	output logic pixel_clk_o,
	output logic out_a_o,
	output logic drive_en_o
);
	import spss_pkg::*;

	// ----------------------------------------
	// Configuration decode
	// ----------------------------------------
	// Only the low byte reaches any logic; upper bits go nowhere.
	logic [`SPSS_CFG_USED-1:0] cfg; // RULE13
	logic pixel_blank_force;
	logic clock_stop_in_vsync;
	logic clock_stop_when_no_data;
	logic vertical_sync_polarity;
	logic data_valid_polarity;
	logic pixel_invert;
	logic pixel_clock_invert;
	logic horizontal_sync_polarity;

	assign cfg = config_i[`SPSS_CFG_USED-1:0]; // RULE13
	assign pixel_blank_force = cfg[`SPSS_BIT_MASK];
	assign clock_stop_in_vsync = cfg[`SPSS_BIT_CLKIDLE];
	assign clock_stop_when_no_data = cfg[`SPSS_BIT_CLKSEL];
	assign vertical_sync_polarity = cfg[`SPSS_BIT_VPOL];
	assign data_valid_polarity = cfg[`SPSS_BIT_DEPOL];
	assign pixel_invert = cfg[`SPSS_BIT_DPOL];
	assign pixel_clock_invert = cfg[`SPSS_BIT_CPOL];
	assign horizontal_sync_polarity = cfg[`SPSS_BIT_HPOL];

	// ----------------------------------------
	// Pixel clock divider
	// ----------------------------------------
	spss_tick_if tick ();

	spss_clk_div u_div (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.en_i(enable_i),
		.div_i(clk_div_i),
		.tick(tick)
	);

	// ----------------------------------------
	// Line and frame timing
	// ----------------------------------------
	spss_phase_e h_ph_q;
	spss_phase_e v_ph_q;
	spss_cnt_t h_cnt_q;
	spss_cnt_t v_cnt_q;
	spss_cnt_t h_len;
	spss_cnt_t v_len;
	logic h_last;
	logic v_last;
	logic line_end;

	always_comb begin
		case (h_ph_q)
			SPSS_PH_SYNC: h_len = h_sync_i;
			SPSS_PH_BACK: h_len = h_back_i;
			SPSS_PH_ACTIVE: h_len = h_active_i;
			default: h_len = h_front_i;
		endcase
	end

	always_comb begin
		case (v_ph_q)
			SPSS_PH_SYNC: v_len = v_sync_i;
			SPSS_PH_BACK: v_len = v_back_i;
			SPSS_PH_ACTIVE: v_len = v_active_i;
			default: v_len = v_front_i;
		endcase
	end

	// A zero-length phase lasts one count; keeps the machine from stalling.
	assign h_last = (h_cnt_q + spss_cnt_t'(1) >= h_len);
	assign v_last = (v_cnt_q + spss_cnt_t'(1) >= v_len);
	assign line_end = tick.rise && h_last && (h_ph_q == SPSS_PH_FRONT);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			h_ph_q <= SPSS_PH_SYNC;
			h_cnt_q <= '0;
		end else if (!enable_i) begin
			h_ph_q <= SPSS_PH_SYNC;
			h_cnt_q <= '0;
		end else if (tick.rise) begin
			if (h_last) begin
				h_cnt_q <= '0;
				case (h_ph_q) // RULE12
					SPSS_PH_SYNC: h_ph_q <= SPSS_PH_BACK;
					SPSS_PH_BACK: h_ph_q <= SPSS_PH_ACTIVE;
					SPSS_PH_ACTIVE: h_ph_q <= SPSS_PH_FRONT;
					default: h_ph_q <= SPSS_PH_SYNC;
				endcase
			end else begin
				h_cnt_q <= h_cnt_q + spss_cnt_t'(1);
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			v_ph_q <= SPSS_PH_SYNC;
			v_cnt_q <= '0;
		end else if (!enable_i) begin
			v_ph_q <= SPSS_PH_SYNC;
			v_cnt_q <= '0;
		end else if (line_end) begin
			if (v_last) begin
				v_cnt_q <= '0;
				case (v_ph_q) // RULE12
					SPSS_PH_SYNC: v_ph_q <= SPSS_PH_BACK;
					SPSS_PH_BACK: v_ph_q <= SPSS_PH_ACTIVE;
					SPSS_PH_ACTIVE: v_ph_q <= SPSS_PH_FRONT;
					default: v_ph_q <= SPSS_PH_SYNC;
				endcase
			end else begin
				v_cnt_q <= v_cnt_q + spss_cnt_t'(1);
			end
		end
	end

	logic vs_act;
	logic hs_act;
	logic de_act;

	assign vs_act = (v_ph_q == SPSS_PH_SYNC);
	assign hs_act = (h_ph_q == SPSS_PH_SYNC);
	assign de_act = (h_ph_q == SPSS_PH_ACTIVE) && (v_ph_q == SPSS_PH_ACTIVE);

	// ----------------------------------------
	// Pixel format reduction
	// ----------------------------------------
	// Each colour keeps its six upper bits; narrower formats are left aligned.
	logic [`SPSS_PIX_OUT_W-1:0] pix18;

	always_comb begin
		case (pixel_format_i) // RULE11
			`SPSS_FMT_565: pix18 = {pixel_i[15:11], pixel_i[15],
				pixel_i[10:5], pixel_i[4:0], pixel_i[4]};
			`SPSS_FMT_666: pix18 = pixel_i[17:0];
			`SPSS_FMT_888: pix18 = {pixel_i[23:18], pixel_i[15:10], pixel_i[7:2]}; // RULE9
			default: pix18 = pixel_i[17:0];
		endcase
	end

	logic [`SPSS_PIX_OUT_W-1:0] pix_shaped;

	always_comb begin
		pix_shaped = de_act ? pix18 : '0;
		if (pixel_invert) begin
			pix_shaped = ~pix_shaped; // RULE6
		end
		if (pixel_blank_force) begin
			pix_shaped = '0; // RULE1
		end
	end

	// ----------------------------------------
	// Pixel clock gating
	// ----------------------------------------
	logic clk_run;
	logic clk_lvl;
	logic lvl_nx;

	assign clk_run = !(clock_stop_in_vsync && vs_act) // RULE2
		&& !(clock_stop_when_no_data && !de_act); // RULE3
	// Divider level after this edge, so the clock rises together with new data
	// and falls half a pixel later, never at the same edge as a data change.
	assign lvl_nx = tick.rise || (tick.level && !tick.fall);
	// Gated clock rests at its idle level; with a divide above one the pulse at each gate change is shortened.
	assign clk_lvl = (clk_run ? lvl_nx : 1'b0) ^ pixel_clock_invert; // RULE7

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Data changes on the divider's rising half so it is stable at the falling
	// edge; the invert bit moves the panel's sampling to the other edge.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pixel_bus_out_o <= '0;
			vsync_o <= 1'b0;
			hsync_o <= 1'b0;
			data_valid_out_o <= 1'b0;
			out_a_o <= 1'b0;
		end else if (!enable_i) begin
			pixel_bus_out_o <= '0; // RULE10
			vsync_o <= 1'b0;
			hsync_o <= 1'b0;
			data_valid_out_o <= 1'b0;
			out_a_o <= 1'b0;
		end else begin
			if (tick.rise) begin
				pixel_bus_out_o <= pix_shaped;
			end
			vsync_o <= vs_act ~^ vertical_sync_polarity; // RULE4
			hsync_o <= hs_act ~^ horizontal_sync_polarity; // RULE8
			data_valid_out_o <= de_act ~^ data_valid_polarity; // RULE5
			out_a_o <= out_a_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pixel_clk_o <= 1'b0;
		end else begin
			pixel_clk_o <= enable_i ? clk_lvl : 1'b0; // RULE10
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drive_en_o <= 1'b0;
		end else begin
			drive_en_o <= enable_i; // RULE10
		end
	end

	// ----------------------------------------
	// Source handshake
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pixel_req_o <= 1'b0;
			frame_start_o <= 1'b0;
		end else begin
			pixel_req_o <= enable_i && tick.rise && de_act;
			frame_start_o <= enable_i && line_end && v_last && (v_ph_q == SPSS_PH_FRONT);
		end
	end
endmodule
`default_nettype wire

/* File: testbench/spss_shaper_assertions.sv */
/* Concurrent checks on the panel shaper's top ports.
 Bound onto spss_shaper; one clock domain, pixel divide of one assumed. */
`timescale 1ns/100ps
`default_nettype none
`include "spss_defs.svh"
module spss_shaper_checker (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic enable_i,
	input wire logic [`SPSS_CFG_W-1:0] config_i,
	input wire logic out_a_i,
	input wire logic [`SPSS_PIX_OUT_W-1:0] pixel_bus_out_o,
	input wire logic vsync_o,
	input wire logic hsync_o,
	input wire logic data_valid_out_o,
	input wire logic pixel_clk_o,
	input wire logic out_a_o,
	input wire logic drive_en_o
);
	// ----
	// Checks
	// ----
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	wire logic dv_on = data_valid_out_o == config_i[4];
	// Settled settings: registered outputs have caught up with them
	sequence s_hold;
		($stable(config_i) && drive_en_o) [*3];
	endsequence
	sequence s_idle;
		!dv_on [*3];
	endsequence
	a_blank_force: assert property (
		config_i[0] [*8] |-> pixel_bus_out_o == '0) else $error("bus not blanked");
	a_vsync_clk_stop: assert property (
		s_hold ##0 config_i[1] && vsync_o == config_i[3] && $past(vsync_o) == config_i[3]
		|-> pixel_clk_o == config_i[6]) else $error("clock runs in vsync");
	a_idle_clk_stop: assert property (
		(s_hold and s_idle) ##0 config_i[2] |-> pixel_clk_o == config_i[6]) else $error("clock runs idle");
	a_clk_free_run: assert property (
		s_hold ##0 !config_i[1] && !config_i[2] |-> ##[1:4] $changed(pixel_clk_o)) else $error("clock stuck");
	a_vsync_apart: assert property (
		s_hold ##0 dv_on |-> vsync_o != config_i[3]) else $error("vsync active with data");
	a_hsync_apart: assert property (
		s_hold ##0 dv_on |-> hsync_o != config_i[7]) else $error("hsync active with data");
	a_idle_invert: assert property (
		(s_hold and s_idle) ##0 !config_i[0] |-> pixel_bus_out_o == {`SPSS_PIX_OUT_W{config_i[5]}})
		else $error("idle bus level wrong");
	a_clk_launch: assert property (
		s_hold ##0 dv_on && !config_i[2] && $changed(pixel_bus_out_o) |-> pixel_clk_o != config_i[6])
		else $error("data launched on sampling edge");
	a_disabled_quiet: assert property (
		!enable_i [*2] |-> {pixel_bus_out_o, vsync_o, hsync_o, data_valid_out_o, pixel_clk_o, out_a_o} == '0)
		else $error("pins driven while disabled");
	a_drive_follow: assert property (
		1'b1 |=> drive_en_o == $past(enable_i) && (!$past(enable_i) || out_a_o == $past(out_a_i)))
		else $error("enable or out_a lag wrong");
endmodule
bind spss_shaper spss_shaper_checker u_chk (.*);
`default_nettype wire

/* File: testbench/spss_panel_model.sv */
/* Panel side model: takes a pixel on its sampling edge while data is valid.
 Assumes the pixel clock runs at no more than half the rate of clk_i. */
`timescale 1ns/100ps
`default_nettype none
module spss_panel_model (
	input wire logic clk_i,
	input wire logic pclk_i,
	input wire logic sample_high_i,
	input wire logic dv_i,
	input wire logic [17:0] data_i,
	output logic [17:0] got_o = 18'h0,
	output logic [15:0] count_o = 16'h0
);
	// ----
	// Sampling
	// ----
	logic pclk_q = 1'b0;
	logic dv_q = 1'b0;
	logic [17:0] data_q = 18'h0;
	always @(posedge clk_i) begin
		pclk_q <= pclk_i;
		dv_q <= dv_i;
		data_q <= data_i;
		// Edge opposite the launch edge; levels are those held just before it
		if (pclk_i != pclk_q && pclk_i == sample_high_i && dv_q) begin
			got_o <= data_q;
			count_o <= count_o + 16'h1;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/test_sync_panel_signal_shaper.sv */
/* Self-checking bench of the panel shaper with a panel model.
 Assumes a divide of one and tiny line and frame counts. */
`timescale 1ns/100ps
`default_nettype none
`include "spss_defs.svh"
`define CMP(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module test_sync_panel_signal_shaper;
	import spss_pkg::*;
	typedef struct {logic [31:0] cfg; logic [1:0] fmt; logic [17:0] exp;} spss_row_s;
	logic clk = 1'b0, rstn = 1'b0, en = 1'b0, oa = 1'b0, req, fs, vs, hs, dv, pclk, oa_o, drv;
	logic [31:0] cfg = 32'h0;
	logic [1:0] fmt = 2'h0;
	logic [7:0] div = 8'h01;
	logic [23:0] pix = 24'hA5C3F0;
	logic [17:0] bus, got;
	spss_cnt_t c1 = 12'h001, c2 = 12'h002;
	int num_errors = 0, n_tests = 0, k, n;
	spss_row_s rows [6] = '{'{32'h98, 2'h2, 18'h29C3C}, '{32'h0, 2'h1, 18'h1C3F0}, '{32'h42, 2'h0, 18'h317E1},
		'{32'hFFFFFF34, 2'h2, 18'h163C3}, '{32'h21, 2'h2, 18'h0}, '{32'h90, 2'h3, 18'h1C3F0}};
	always #4 clk = ~clk;
	spss_shaper dut (.sys_clk_i(clk), .rstn_i(rstn), .enable_i(en), .config_i(cfg), .pixel_format_i(fmt),
		.clk_div_i(div), .h_sync_i(c1), .h_back_i(c1), .h_active_i(c2), .h_front_i(c1), .v_sync_i(c1),
		.v_back_i(c1), .v_active_i(c2), .v_front_i(c1), .out_a_i(oa), .pixel_i(pix), .pixel_req_o(req),
		.frame_start_o(fs), .pixel_bus_out_o(bus), .vsync_o(vs), .hsync_o(hs), .data_valid_out_o(dv),
		.pixel_clk_o(pclk), .out_a_o(oa_o), .drive_en_o(drv));
	spss_panel_model panel (.clk_i(clk), .pclk_i(pclk), .sample_high_i(cfg[6]), .dv_i(dv == cfg[4]),
		.data_i(bus), .got_o(got), .count_o());
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wait_req();
		k = 0;
		@(negedge clk);
		while (req !== 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic run_row(input spss_row_s r);
		cfg = r.cfg;
		fmt = r.fmt;
		oa = ~oa;
		repeat (2) wait_req();
		`CMP(bus, r.exp)
		repeat (2) @(negedge clk);
		`CMP(got, r.exp)
	endtask
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		en = 1'b1;
		foreach (rows[i]) run_row(rows[i]);
		// Frame length and pixel count between two frame starts
		k = 0;
		n = 0;
		while (fs !== 1'b1 && k < 500) begin
			@(negedge clk);
			k++;
		end
		k = 0;
		do begin
			@(negedge clk);
			n += (req === 1'b1);
			k++;
		end while (fs !== 1'b1 && k < 500);
		`CMP(n, 4)
		`CMP(k, 50)
		en = 1'b0;
		repeat (3) @(negedge clk);
		`CMP({bus, vs, hs, dv, pclk, oa_o, drv}, 24'h0)
		en = 1'b1;
		run_row(rows[2]);
		rstn = 1'b0;
		@(negedge clk);
		`CMP({bus, vs, hs, dv, pclk, oa_o, drv}, 24'h0)
		rstn = 1'b1;
		run_row(rows[3]);
		end_of_test();
	end
endmodule
`default_nettype wire
